// [id_incrementer.v]
// next expected identifier: lba or chs stepping
`timescale 1ns/10ps
`include "sector_track_regs.vh"
module id_incrementer (
  // current identifier and format
  input  wire [`ID_WIDTH-1:0] id_i,
  input  wire                 lba_fmt_i,
  input  wire                 lba_len4_i,
  input  wire [7:0]           max_sector_i,
  input  wire [7:0]           max_head_i,
  // stepped identifier
  output reg  [`ID_WIDTH-1:0] id_o
);
  // byte 0 cylinder high, 1 cylinder low, 2 head, 3 sector
  reg [15:0] cyl;
  always @* begin
    cyl  = {id_i[7:0], id_i[15:8]};
    id_o = id_i;
    if (lba_fmt_i == `FMT_LBA) begin
      if (lba_len4_i == `LBA_LEN_4)
        id_o[31:0] = id_i[31:0] + 32'h00000001;
      else
        id_o[23:0] = id_i[23:0] + 24'h000001;
    end else begin
      if (id_i[31:24] < max_sector_i)
        id_o[31:24] = id_i[31:24] + 8'h01;
      else begin
        id_o[31:24] = 8'h01;
        if (id_i[23:16] < max_head_i)
          id_o[23:16] = id_i[23:16] + 8'h01;
        else begin
          id_o[23:16] = 8'h00;
          cyl         = cyl + 16'h0001;
          id_o[15:0]  = {cyl[7:0], cyl[15:8]};
        end
      end
    end
  end
endmodule // id_incrementer

// [sector_id_count_tracker.v]
// disk-side sector identifier groups and block/buffer counters
`timescale 1ns/10ps
`include "sector_track_regs.vh"
module sector_id_count_tracker #(
  parameter CW = `CNT_WIDTH
) (
  // clock and reset
  input  wire                  clk_i,
  input  wire                  srst_i,
  // configuration
  input  wire                  lba_fmt_i,
  input  wire                  lba_len4_i,
  input  wire [7:0]            max_sector_i,
  input  wire [7:0]            max_head_i,
  input  wire                  skip_mode_i,
  input  wire                  exp_id_load_i,
  input  wire [`ID_WIDTH-1:0]  exp_id_load_val_i,
  // identifier byte stream from the disk sequencer
  input  wire                  id_start_i,
  input  wire                  id_byte_vld_i,
  input  wire [7:0]            id_byte_i,
  input  wire                  id_done_i,
  input  wire                  id_crc_ok_i,
  // sector progress
  input  wire                  data_end_i,
  input  wire                  sector_end_i,
  input  wire                  skipped_block_i,
  input  wire                  disk_write_i,
  input  wire                  ecc_error_i,
  input  wire                  correction_ok_strobe_i,
  input  wire                  uncorrectable_i,
  input  wire [`ADDR_WIDTH-1:0] block_start_addr_i,
  input  wire                  buf_dec_i,
  // pipeline boundary
  input  wire                  pipe_load_i,
  input  wire [CW-1:0]         pipe_block_count_i,
  // processor actions
  input  wire                  capture_clear_i,
  input  wire                  snapshot_i,
  input  wire                  pending_clear_i,
  // identifier groups and flags
  output reg  [`ID_WIDTH-1:0]  expected_id_o,
  output reg  [`ID_WIDTH-1:0]  primary_id_o,
  output reg  [`ID_WIDTH-1:0]  secondary_id_o,
  output reg  [`ID_WIDTH-1:0]  capture_id_o,
  output reg                   capture_full_flag_o,
  output reg                   capture_irq_o,
  output reg                   primary_group_active_o,
  output reg                   primary_group_error_o,
  output reg                   secondary_group_active_o,
  output reg                   secondary_group_error_o,
  // counts
  output reg  [CW-1:0]         int_block_count_o,
  output reg  [CW-1:0]         ext_block_count_o,
  output reg  [CW-1:0]         buffer_counter_o,
  output reg  [CW-1:0]         buffer_snap_o,
  output reg  [CW-1:0]         block_snap_o,
  output reg                   more_blocks_o,
  output reg                   pending_increment_flag_o,
  output reg                   sequencer_halt_o,
  output reg  [`ADDR_WIDTH-1:0] ecc_start_addr_o
);
  localparam [1:0] ST_IDLE     = `ST_IDLE;
  localparam [1:0] ST_WAIT_ECC = `ST_WAIT_ECC;
  localparam [1:0] ST_BAD      = `ST_BAD;

  reg  [`ID_WIDTH-1:0] rx_q;
  reg  [2:0]           rx_idx_q;
  reg                  match_q;
  reg  [1:0]           ecc_st_q;
  reg                  use_b_q;
  reg                  halt_arm_q;
  reg                  ext_held_q;
  wire [`ID_WIDTH-1:0] exp_next;
  wire [`ID_WIDTH-1:0] rx_next;
  wire                 id_good;
  wire                 int_next_zero;
  wire                 clean_end;
  wire                 skip_end;
  wire                 good_sector;
  wire                 buf_up;
  wire [CW-1:0]        cnt_one;

  id_incrementer u_inc (
    .id_i         (expected_id_o),
    .lba_fmt_i    (lba_fmt_i),
    .lba_len4_i   (lba_len4_i),
    .max_sector_i (max_sector_i),
    .max_head_i   (max_head_i),
    .id_o         (exp_next)
  );

  // byte lands at its own lane so capture fills as bytes arrive
  genvar g;
  generate
    for (g = 0; g < `ID_BYTES; g = g + 1) begin : lane
      assign rx_next[g*8 +: 8] = (id_byte_vld_i && rx_idx_q == g) ? id_byte_i : rx_q[g*8 +: 8];
    end
  endgenerate

  assign id_good       = id_done_i && id_crc_ok_i;
  assign int_next_zero = (int_block_count_o == {{(CW-1){1'b0}}, 1'b1});
  assign cnt_one       = {{(CW-1){1'b0}}, 1'b1};
  // a sector that ends while a correction is outstanding is not counted here
  assign clean_end     = sector_end_i && !ecc_error_i && ecc_st_q == ST_IDLE;
  assign skip_end      = clean_end && skipped_block_i && skip_mode_i;
  assign good_sector   = clean_end && !skip_end && (!skipped_block_i || disk_write_i);
  // a landed correction releases the held increment of the bad sector
  assign buf_up        = good_sector || (ecc_st_q == ST_WAIT_ECC && correction_ok_strobe_i);

  // identifier path
  always @(posedge clk_i) begin
    if (srst_i) begin
      rx_q                     <= `ID_RESET;
      rx_idx_q                 <= 3'h0;
      match_q                  <= 1'b0;
      expected_id_o            <= `ID_RESET;
      primary_id_o             <= `ID_RESET;
      secondary_id_o           <= `ID_RESET;
      capture_id_o             <= `ID_RESET;
      capture_full_flag_o      <= 1'b0;
      capture_irq_o            <= 1'b0;
      use_b_q                  <= 1'b0;
      primary_group_active_o   <= 1'b0;
      primary_group_error_o    <= 1'b0;
      secondary_group_active_o <= 1'b0;
      secondary_group_error_o  <= 1'b0;
    end else begin
      capture_irq_o <= 1'b0;
      if (id_start_i) begin
        rx_q     <= `ID_RESET;
        rx_idx_q <= 3'h0;
      end else if (id_byte_vld_i) begin
        rx_q     <= rx_next;
        rx_idx_q <= rx_idx_q + 3'h1;
        // a full capture is frozen until the processor clears it
        if (!capture_full_flag_o)
          capture_id_o <= rx_next;
      end
      // a bad crc must not leave an earlier match armed for the next data end
      if (id_done_i && !id_crc_ok_i)
        match_q <= 1'b0;
      if (id_good) begin
        match_q <= (lba_fmt_i == `FMT_LBA && lba_len4_i == `LBA_LEN_3) ?
                   (rx_q[23:0] == expected_id_o[23:0]) :
                   (rx_q[31:0] == expected_id_o[31:0]);
        if (!capture_full_flag_o) begin
          capture_full_flag_o <= 1'b1;
          capture_irq_o       <= 1'b1;
        end
        // primary stays frozen on a bad sector, so it keeps that id
        if (use_b_q) begin
          secondary_id_o           <= rx_q;
          secondary_group_active_o <= 1'b1;
        end else begin
          primary_id_o           <= rx_q;
          primary_group_active_o <= 1'b1;
        end
      end else if (capture_clear_i) begin
        capture_full_flag_o <= 1'b0;
      end
      if (exp_id_load_i)
        expected_id_o <= exp_id_load_val_i;
      else if (data_end_i && match_q) begin
        expected_id_o <= exp_next;
        match_q       <= 1'b0;
      end
      if (ecc_error_i && !use_b_q) begin
        use_b_q               <= 1'b1;
        primary_group_error_o <= 1'b1;
      end else if (ecc_error_i)
        secondary_group_error_o <= 1'b1;
      else if (correction_ok_strobe_i && ecc_st_q == ST_WAIT_ECC) begin
        use_b_q                  <= 1'b0;
        primary_group_error_o    <= 1'b0;
        secondary_group_error_o  <= 1'b0;
        secondary_group_active_o <= 1'b0;
      end else if (pending_clear_i && ecc_st_q == ST_BAD) begin
        // software has taken the bad sector's id, so both groups return to normal use
        use_b_q                  <= 1'b0;
        primary_group_error_o    <= 1'b0;
        secondary_group_error_o  <= 1'b0;
        secondary_group_active_o <= 1'b0;
      end
    end
  end

  // counters and ecc bookkeeping; plain processor reads touch nothing here
  always @(posedge clk_i) begin
    if (srst_i) begin
      int_block_count_o        <= `CNT_RESET;
      ext_block_count_o        <= `CNT_RESET;
      buffer_counter_o         <= `CNT_RESET;
      buffer_snap_o            <= `CNT_RESET;
      block_snap_o             <= `CNT_RESET;
      more_blocks_o            <= 1'b0;
      pending_increment_flag_o <= 1'b0;
      sequencer_halt_o         <= 1'b0;
      ecc_start_addr_o         <= `ADDR_RESET;
      ecc_st_q                 <= ST_IDLE;
      halt_arm_q               <= 1'b0;
      ext_held_q               <= 1'b0;
    end else begin
      if (snapshot_i) begin
        buffer_snap_o <= buffer_counter_o;
        block_snap_o  <= ext_block_count_o;
      end
      if (pipe_load_i) begin
        int_block_count_o <= pipe_block_count_i;
        ext_block_count_o <= pipe_block_count_i;
        more_blocks_o     <= (pipe_block_count_i != `CNT_RESET);
        // an error flagged in this very cycle still belongs to the old pipeline
        if (ecc_st_q == ST_WAIT_ECC || (ecc_error_i && ecc_st_q == ST_IDLE))
          pending_increment_flag_o <= 1'b1;
      end else if (sector_end_i && int_block_count_o != `CNT_RESET) begin
        int_block_count_o <= int_block_count_o - {{(CW-1){1'b0}}, 1'b1};
        more_blocks_o     <= !int_next_zero;
      end
      if (ecc_error_i && ecc_st_q == ST_IDLE) begin
        ecc_st_q         <= ST_WAIT_ECC;
        ecc_start_addr_o <= block_start_addr_i;
        ext_held_q       <= pipe_load_i;
      end
      case (ecc_st_q)
        ST_IDLE: begin
          // a boundary in the same cycle wins: the new pipeline's count stands
          if (!pipe_load_i) begin
            if (skip_end)
              ext_block_count_o <= ext_block_count_o - cnt_one;
            else if (good_sector)
              ext_block_count_o <= ext_block_count_o - cnt_one;
          end
        end
        ST_WAIT_ECC: begin
          // limitation: a further sector ending before the outcome is not counted,
          // so the sequencer must wait for the correction result first
          if (pipe_load_i)
            ext_held_q <= 1'b1;
          if (correction_ok_strobe_i) begin
            ecc_st_q                 <= ST_IDLE;
            pending_increment_flag_o <= 1'b0;
            ext_held_q               <= 1'b0;
            if (!ext_held_q && !pipe_load_i)
              ext_block_count_o <= ext_block_count_o - cnt_one;
          end else if (uncorrectable_i) begin
            ecc_st_q   <= ST_BAD;
            halt_arm_q <= 1'b1;
          end
        end
        ST_BAD: begin
          // sector ends no longer step the ext or buffer counts until software releases this state; a new pipeline does not
          if (pending_clear_i) begin
            ecc_st_q                 <= ST_IDLE;
            pending_increment_flag_o <= 1'b0;
            sequencer_halt_o         <= 1'b0;
            halt_arm_q               <= 1'b0;
            ext_held_q               <= 1'b0;
          end
        end
        default: ecc_st_q <= ST_IDLE;
      endcase
      // host removals are never held back by the ecc state, only arrivals are
      if (buf_up && !buf_dec_i)
        buffer_counter_o <= buffer_counter_o + cnt_one;
      else if (buf_dec_i && !buf_up)
        buffer_counter_o <= buffer_counter_o - cnt_one;
      if (halt_arm_q && sector_end_i) begin
        sequencer_halt_o <= 1'b1;
        halt_arm_q       <= 1'b0;
      end
    end
  end
endmodule // sector_id_count_tracker

// [sector_id_count_tracker_bench.sv]
// self-checking testbench for the sector identifier and count tracker
`timescale 1ns/10ps
module sector_id_count_tracker_bench;
  localparam ST = 0, BV = 1, DN = 2, DE = 3, SE = 4, EE = 5, CO = 6, UC = 7, PL = 8, SN = 9, CC = 10, PC = 11, EL = 12;
  reg         clk_i, srst_i, crc_ok, lba, len4, skm, skb;
  reg  [12:0] p;
  reg  [7:0]  id_byte;
  reg  [15:0] pipe_cnt;
  reg  [63:0] exp_val;
  reg  [21:0] addr;
  integer     mismatches, checks, i;
  wire [63:0] exp_id, pri_id, sec_id, cap_id;
  wire [15:0] int_cnt, ext_cnt, buf_cnt, buf_snap, blk_snap;
  wire [21:0] ecc_addr;
  wire        full, pa, pe, sa, se, more, pend, halt;
  sector_id_count_tracker i_dut (.clk_i(clk_i), .srst_i(srst_i), .lba_fmt_i(lba), .lba_len4_i(len4),
    .max_sector_i(8'h3F), .max_head_i(8'h0F), .skip_mode_i(skm), .exp_id_load_i(p[EL]), .exp_id_load_val_i(exp_val),
    .id_start_i(p[ST]), .id_byte_vld_i(p[BV]), .id_byte_i(id_byte), .id_done_i(p[DN]), .id_crc_ok_i(crc_ok),
    .data_end_i(p[DE]), .sector_end_i(p[SE]), .skipped_block_i(skb), .disk_write_i(1'b0), .ecc_error_i(p[EE]),
    .correction_ok_strobe_i(p[CO]), .uncorrectable_i(p[UC]), .block_start_addr_i(addr), .buf_dec_i(1'b0),
    .pipe_load_i(p[PL]), .pipe_block_count_i(pipe_cnt), .capture_clear_i(p[CC]), .snapshot_i(p[SN]),
    .pending_clear_i(p[PC]), .expected_id_o(exp_id), .primary_id_o(pri_id), .secondary_id_o(sec_id),
    .capture_id_o(cap_id), .capture_full_flag_o(full), .capture_irq_o(), .primary_group_active_o(pa),
    .primary_group_error_o(pe), .secondary_group_active_o(sa), .secondary_group_error_o(se),
    .int_block_count_o(int_cnt), .ext_block_count_o(ext_cnt), .buffer_counter_o(buf_cnt), .buffer_snap_o(buf_snap),
    .block_snap_o(blk_snap), .more_blocks_o(more), .pending_increment_flag_o(pend), .sequencer_halt_o(halt),
    .ecc_start_addr_o(ecc_addr));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task chk(input [63:0] got, input [63:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one-cycle strobe at a falling edge, then an idle cycle so p changes once per step
  task pulse(input [3:0] b);
    begin
      p = 13'h0001 << b;
      @(negedge clk_i);
      p = 13'h0000;
      @(negedge clk_i);
    end
  endtask
  task rd_id(input [31:0] id, input ok);
    begin
      pulse(ST);
      for (i = 0; i < 4; i = i + 1) begin
        id_byte = id[8*i +: 8];
        pulse(BV);
      end
      crc_ok = ok;
      pulse(DN);
    end
  endtask
  task sect(input [31:0] id, input err);
    begin
      rd_id(id, 1'b1);
      pulse(DE);
      if (err) pulse(EE);
      pulse(SE);
    end
  endtask
  task t_good;
    begin
      exp_val = 64'h7; pulse(EL); pipe_cnt = 16'h3; pulse(PL);
      rd_id(32'h7, 1'b1);
      chk(cap_id, 64'h7);
      chk(full, 1);
      chk(pri_id, 64'h7);
      pulse(CC); chk(full, 0);
      pulse(DE); chk(exp_id, 64'h8);
      pulse(SE); chk({int_cnt, ext_cnt, buf_cnt}, 48'h0002_0002_0001);
      chk(more, 1);
      rd_id(32'h5, 1'b1); pulse(CC);
      rd_id(32'h8, 1'b0); chk(full, 0);
      pulse(DE); chk(exp_id, 64'h8);
      pulse(SN); chk(buf_snap, 64'h1);
      $display("good sector test done");
    end
  endtask
  task t_err;
    begin
      sect(32'h8, 1'b1); chk({ext_cnt, buf_cnt}, 32'h0002_0001);
      chk(pe, 1);
      pulse(CO); chk({ext_cnt, buf_cnt}, 32'h0001_0002);
      chk(pe, 0);
      addr = 22'h2A5; sect(32'h9, 1'b1); pulse(UC);
      chk({ext_cnt, buf_cnt}, 32'h0001_0002);
      chk(ecc_addr, 64'h2A5);
      rd_id(32'hA, 1'b1);
      chk(sec_id, 64'hA);
      chk(sa, 1);
      chk(pri_id, 64'h9);
      pulse(DE); pulse(SE); chk(halt, 1);
      chk({ext_cnt, buf_cnt}, 32'h0001_0002);
      pulse(PC); chk(halt, 0);
      $display("ecc error test done");
    end
  endtask
  task t_pipe;
    begin
      exp_val = 64'h20; pulse(EL); sect(32'h20, 1'b1);
      pipe_cnt = 16'h5; pulse(PL); chk(pend, 1);
      chk({int_cnt, ext_cnt}, 32'h0005_0005);
      pulse(CO); chk({pend, ext_cnt, buf_cnt}, 33'h0_0005_0003);
      sect(32'h21, 1'b1); pipe_cnt = 16'h6; pulse(PL); pulse(UC);
      chk({pend, buf_cnt}, 17'h1_0003);
      $display("pipeline boundary test done");
    end
  endtask
  task t_fmt;
    begin
      lba = 1'b0; exp_val = 64'h3F0FFF01; pulse(EL);
      rd_id(32'h3F0FFF01, 1'b1); pulse(DE); chk(exp_id, 64'h01000002);
      lba = 1'b1; len4 = 1'b0; exp_val = 64'h12FFFFFF; pulse(EL);
      rd_id(32'h00FFFFFF, 1'b1); pulse(DE); chk(exp_id, 64'h12000000);
      len4 = 1'b1;
      $display("identifier format test done");
    end
  endtask
  task t_skip;
    begin
      chk(pe, 1);
      pulse(PC); chk({pe, se, sa, pend, halt}, 5'h00);
      pipe_cnt = 16'h4; pulse(PL);
      skm = 1'b1; skb = 1'b1; pulse(SE);
      chk({int_cnt, ext_cnt, buf_cnt}, 48'h0003_0003_0003);
      skm = 1'b0; skb = 1'b0; pulse(SE);
      chk({int_cnt, ext_cnt, buf_cnt}, 48'h0002_0002_0004);
      pulse(SN); chk(blk_snap, 64'h2);
      $display("skip mode test done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  initial begin
    srst_i = 1'b1; p = 13'h0000; crc_ok = 1'b0; lba = 1'b1; len4 = 1'b1; id_byte = 8'h00;
    pipe_cnt = 16'h0000; exp_val = 64'h0; addr = 22'h000000; mismatches = 0; checks = 0; skm = 1'b0; skb = 1'b0;
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    t_good;
    t_err;
    t_pipe;
    t_fmt;
    t_skip;
    tally_and_finish;
  end
endmodule // sector_id_count_tracker_bench

// [sector_id_count_tracker_checker.sv]
// assertion checker for the sector identifier and count tracker
`timescale 1ns/10ps
module sector_id_count_tracker_checker #(parameter CW = 16) (
  // clock, reset and causes
  input wire          clk_i, srst_i, id_done_i, id_crc_ok_i, data_end_i, exp_id_load_i, capture_clear_i,
  input wire          snapshot_i, pipe_load_i, correction_ok_strobe_i, sector_end_i, buf_dec_i,
  input wire [CW-1:0] pipe_block_count_i,
  // observed outputs
  input wire          capture_full_flag_o, capture_irq_o, pending_increment_flag_o,
  input wire [63:0]   expected_id_o, capture_id_o,
  input wire [CW-1:0] int_block_count_o, ext_block_count_o, buffer_counter_o, buffer_snap_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_full_set; id_done_i && id_crc_ok_i && !capture_full_flag_o |=> capture_full_flag_o && capture_irq_o; endproperty
  a_full_set: assert property (p_full_set) else $error("capture flag or irq missing");
  property p_irq_once; capture_irq_o |=> !capture_irq_o; endproperty
  a_irq_once: assert property (p_irq_once) else $error("capture irq longer than one cycle");
  property p_bad_crc; id_done_i && !id_crc_ok_i && !capture_full_flag_o |=> !capture_full_flag_o; endproperty
  a_bad_crc: assert property (p_bad_crc) else $error("capture flag set on bad crc");
  property p_clear; capture_full_flag_o && capture_clear_i && !id_done_i |=> !capture_full_flag_o; endproperty
  a_clear: assert property (p_clear) else $error("capture flag not cleared");
  property p_hold; capture_full_flag_o && !capture_clear_i |=> $stable(capture_id_o); endproperty
  a_hold: assert property (p_hold) else $error("capture group changed while full");
  property p_exp_hold; !data_end_i && !exp_id_load_i |=> $stable(expected_id_o); endproperty
  a_exp_hold: assert property (p_exp_hold) else $error("expected id moved without data end");
  property p_reload;
    pipe_load_i |=> int_block_count_o == $past(pipe_block_count_i) && ext_block_count_o == $past(pipe_block_count_i);
  endproperty
  a_reload: assert property (p_reload) else $error("block counts not reloaded");
  property p_snap; snapshot_i |=> buffer_snap_o == $past(buffer_counter_o); endproperty
  a_snap: assert property (p_snap) else $error("buffer snapshot wrong");
  // reads never appear as causes, so the count may move only on these events
  property p_buf_hold;
    !sector_end_i && !correction_ok_strobe_i && !buf_dec_i && !pipe_load_i |=> $stable(buffer_counter_o);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buffer count moved without cause");
  property p_pend_clr;
    pending_increment_flag_o && correction_ok_strobe_i && !pipe_load_i && !sector_end_i && !buf_dec_i
      |=> !pending_increment_flag_o && buffer_counter_o == CW'($past(buffer_counter_o) + 1'b1);
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending increment not applied");
  c_irq: cover property (capture_irq_o);
  c_pend: cover property (pending_increment_flag_o && correction_ok_strobe_i);
  c_snap: cover property (snapshot_i);
endmodule // sector_id_count_tracker_checker
bind sector_id_count_tracker sector_id_count_tracker_checker #(.CW(CW)) i_chk (
  .clk_i(clk_i), .srst_i(srst_i), .id_done_i(id_done_i), .id_crc_ok_i(id_crc_ok_i), .data_end_i(data_end_i),
  .exp_id_load_i(exp_id_load_i), .capture_clear_i(capture_clear_i), .snapshot_i(snapshot_i),
  .pipe_load_i(pipe_load_i), .correction_ok_strobe_i(correction_ok_strobe_i), .sector_end_i(sector_end_i),
  .buf_dec_i(buf_dec_i), .pipe_block_count_i(pipe_block_count_i), .capture_full_flag_o(capture_full_flag_o),
  .capture_irq_o(capture_irq_o), .pending_increment_flag_o(pending_increment_flag_o),
  .expected_id_o(expected_id_o), .capture_id_o(capture_id_o), .int_block_count_o(int_block_count_o),
  .ext_block_count_o(ext_block_count_o), .buffer_counter_o(buffer_counter_o), .buffer_snap_o(buffer_snap_o));

// [sector_track_regs.vh]
// constants for the sector identifier and count tracker
`ifndef SECTOR_TRACK_REGS_VH
`define SECTOR_TRACK_REGS_VH
`define ID_BYTES         8
`define ID_WIDTH         64
`define CNT_WIDTH        16
`define FMT_CHS          1'b0
`define FMT_LBA          1'b1
`define LBA_LEN_3        1'b0
`define LBA_LEN_4        1'b1
`define ID_RESET         64'h0000000000000000
`define CNT_RESET        16'h0000
`define ADDR_WIDTH       22
`define ADDR_RESET       22'h000000
`define ST_IDLE          2'h0
`define ST_WAIT_ECC      2'h1
`define ST_BAD           2'h2
`endif
